// [rtl/bad_bit_unit.sv]
// bit processor: bit address decode, bit storage and single-bit ops
`timescale 1ns/1ns
`default_nettype none
module bad_bit_unit
  import bad_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        op_valid_i,
  input  wire bad_op_t     op_code_i,
  input  wire logic [7:0]  bit_addr_i,
  input  wire logic [7:0]  disp_i,
  input  wire logic [15:0] next_pc_i,
  input  wire logic [7:0]  byte_addr_i,
  input  wire logic        byte_wr_i,
  input  wire logic [7:0]  byte_wdata_i,
  output logic      [7:0]  byte_rdata_o,
  output logic             op_done_o,
  output logic      [1:0]  instr_len_o,
  output logic             branch_taken_o,
  output logic      [15:0] branch_target_o,
  output logic             bit_value_o,
  output logic             carry_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_RAM_BYTES-1:0][7:0] ram;
    logic [NUM_SFR-1:0][7:0]       sfr;
    logic                          done;
    logic                          taken;
    logic [15:0]                   target;
    logic                          bit_val;
    logic [7:0]                    rd_data;
    logic [1:0]                    len;
  } bad_state_t;

  bad_state_t q;
  bad_state_t next_q;
  logic [1:0] rst_pipe;
  logic       rst_n;

  // reset release through two flops
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [7:0] dec_byte;
  logic [2:0] dec_pos;
  logic       dec_ram;
  logic       dec_ok;

  bad_addr_decode u_decode (
    .bit_addr_i    (bit_addr_i),
    .byte_addr_o   (dec_byte),
    .bit_pos_o     (dec_pos),
    .is_ram_o      (dec_ram),
    .implemented_o (dec_ok)
  );

  // ---------------------------------------------------------------
  // byte access helpers
  // ---------------------------------------------------------------
  // true when address falls in the bit RAM block
  function automatic logic in_ram(input logic [7:0] addr);
    in_ram = (addr >= RAM_BIT_BASE) && (addr <= RAM_BIT_LAST);
  endfunction : in_ram

  // byte read; reserved and absent addresses read zero
  function automatic logic [7:0] read_byte(input bad_state_t s,
                                           input logic [7:0] addr);
    logic [3:0] idx;
    idx = sfr_index(addr);
    if (in_ram(addr)) begin
      read_byte = s.ram[addr[3:0]];
    end else if (idx != SFR_NONE) begin
      read_byte = s.sfr[idx] & sfr_mask(idx);
    end else begin
      read_byte = 8'h00;
    end
  endfunction : read_byte

  // byte write; absent addresses and bits take nothing
  function automatic bad_state_t write_byte(input bad_state_t s,
                                            input logic [7:0] addr,
                                            input logic [7:0] data);
    logic [3:0] idx;
    bad_state_t r;
    idx = sfr_index(addr);
    r   = s;
    if (in_ram(addr)) begin
      r.ram[addr[3:0]] = data;
    end else if (idx != SFR_NONE) begin
      r.sfr[idx] = data & sfr_mask(idx);
    end
    write_byte = r;
  endfunction : write_byte

  // ---------------------------------------------------------------
  // operation execute
  // ---------------------------------------------------------------
  logic [7:0] old_byte;
  logic [7:0] new_byte;
  logic       old_bit;
  logic       carry;
  logic       new_carry;
  logic       wr_bit;
  logic       new_bit;
  logic       take;

  // next state from the operation or the byte port
  always_comb begin
    next_q    = q;
    old_byte  = read_byte(q, dec_byte);
    old_bit   = old_byte[dec_pos];
    carry     = q.sfr[IDX_STATUS][CARRY_POS];
    new_carry = carry;
    wr_bit    = 1'b0;
    new_bit   = old_bit;
    take      = 1'b0;
    case (op_code_i)
      OP_SET_CARRY:          new_carry = 1'b1;
      OP_CLEAR_CARRY:        new_carry = 1'b0;
      OP_INVERT_CARRY:       new_carry = !carry;
      OP_SET_BIT_OP: begin
        wr_bit  = 1'b1;
        new_bit = 1'b1;
      end
      OP_CLEAR_BIT_OP: begin
        wr_bit  = 1'b1;
        new_bit = 1'b0;
      end
      OP_INVERT_BIT_OP: begin
        wr_bit  = 1'b1;
        new_bit = !old_bit;
      end
      OP_AND_INTO_CARRY:     new_carry = carry & old_bit;
      OP_AND_NOT_INTO_CARRY: new_carry = carry & !old_bit;
      OP_OR_INTO_CARRY:      new_carry = carry | old_bit;
      OP_OR_NOT_INTO_CARRY:  new_carry = carry | !old_bit;
      OP_TRANSFER_TO_CARRY:  new_carry = old_bit;
      OP_TRANSFER_TO_BIT: begin
        wr_bit  = 1'b1;
        new_bit = carry;
      end
      OP_BRANCH_IF_SET:      take = old_bit;
      OP_BRANCH_IF_CLEAR:    take = !old_bit;
      OP_BRANCH_SET_CLEAR: begin
        take    = old_bit;
        wr_bit  = old_bit;
        new_bit = 1'b0;
      end
      default: ;
    endcase
    new_byte          = old_byte;
    new_byte[dec_pos] = new_bit;
    next_q.done    = op_valid_i;
    next_q.taken   = op_valid_i && take;
    next_q.target  = next_pc_i + {{8{disp_i[7]}}, disp_i};
    next_q.len     = op_length(op_code_i);
    next_q.bit_val = old_bit;
    next_q.rd_data = read_byte(q, byte_addr_i);
    if (op_valid_i) begin
      next_q.sfr[IDX_STATUS][CARRY_POS] = new_carry;
      if (wr_bit && dec_ok) begin
        next_q = write_byte(next_q, dec_byte, new_byte);
      end
    end else if (byte_wr_i) begin
      next_q = write_byte(next_q, byte_addr_i, byte_wdata_i);
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      q.ram     <= {NUM_RAM_BYTES{RAM_RESET}};
      q.sfr     <= {NUM_SFR{SFR_RESET}};
      q.done    <= 1'b0;
      q.taken   <= 1'b0;
      q.target  <= 16'h0000;
      q.bit_val <= 1'b0;
      q.rd_data <= 8'h00;
      q.len     <= LEN_CARRY;
    end else begin
      q <= next_q;
    end
  end

  // outputs
  assign byte_rdata_o    = q.rd_data;
  assign op_done_o       = q.done;
  assign instr_len_o     = q.len;
  assign branch_taken_o  = q.taken;
  assign branch_target_o = q.target;
  assign bit_value_o     = q.bit_val;
  assign carry_o         = q.sfr[IDX_STATUS][CARRY_POS];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  group_select_a: assert property (
    dec_ram == !bit_addr_i[GROUP_SEL_POS])
    else $error("bit group choice wrong");

  sfr_byte_a: assert property (
    bit_addr_i[GROUP_SEL_POS] |->
      (dec_byte == {bit_addr_i[7:3], 3'h0}) &&
      (dec_pos == bit_addr_i[2:0]))
    else $error("register bit mapping wrong");

  ram_bit_set_a: assert property (
    (op_valid_i && op_code_i == OP_SET_BIT_OP && dec_ram) |=>
      q.ram[$past(bit_addr_i[6:3])][$past(bit_addr_i[2:0])])
    else $error("ram bit not set");

  other_bits_a: assert property (
    (op_valid_i && op_code_i == OP_INVERT_BIT_OP && dec_ram) |=>
      ((q.ram[$past(bit_addr_i[6:3])] ^
        $past(q.ram[bit_addr_i[6:3]])) ==
       (8'h01 << $past(bit_addr_i[2:0]))))
    else $error("bit write disturbed neighbours");

  carry_ops_a: assert property (
    (op_valid_i && op_code_i == OP_INVERT_CARRY) |=>
      (carry_o != $past(carry_o)) && op_done_o &&
      (instr_len_o == LEN_CARRY))
    else $error("carry invert failed");

  jump_clear_a: assert property (
    (op_valid_i && op_code_i == OP_BRANCH_SET_CLEAR && old_bit &&
     dec_ram) |=>
      branch_taken_o && !q.ram[$past(bit_addr_i[6:3])]
                               [$past(bit_addr_i[2:0])])
    else $error("set-then-clear branch wrong");

  branch_target_a: assert property (
    op_valid_i |=> branch_target_o ==
      $past(next_pc_i) + {{8{$past(disp_i[7])}}, $past(disp_i)})
    else $error("branch target wrong");

  stored_kept_a: assert property (
    (op_valid_i && op_code_i == OP_AND_NOT_INTO_CARRY) |=>
      (carry_o == ($past(carry) & !$past(old_bit))) &&
      (q.ram == $past(q.ram)) &&
      ((read_byte(q, $past(dec_byte)) == $past(old_byte)) ||
       ($past(dec_byte) == ADDR_STATUS)))
    else $error("complemented and changed state");

  unimpl_zero_a: assert property (
    ((q.sfr[IDX_IEN] & ~IEN_IMPL_MASK) == 8'h00) &&
    ((q.sfr[IDX_IPRI] & ~IPRI_IMPL_MASK) == 8'h00))
    else $error("unimplemented bit holds a one");

  ram_range_a: assert property (
    !bit_addr_i[GROUP_SEL_POS] |->
      (dec_byte >= RAM_BIT_BASE) && (dec_byte <= RAM_BIT_LAST) && dec_ok)
    else $error("ram bit outside bit block");

  bit_clear_a: assert property (
    (op_valid_i && op_code_i == OP_CLEAR_BIT_OP && dec_ok && !dec_ram) |=>
      !q.sfr[sfr_index($past(dec_byte))][$past(dec_pos)])
    else $error("register bit not cleared");

  branch_len_a: assert property (
    (op_valid_i && op_code_i inside {OP_BRANCH_IF_SET, OP_BRANCH_IF_CLEAR,
                                     OP_BRANCH_SET_CLEAR}) |=>
      op_done_o && (instr_len_o == LEN_BRANCH))
    else $error("branch length wrong");

  status_carry_a: assert property (
    (!op_valid_i && byte_wr_i && byte_addr_i == ADDR_STATUS) |=>
      carry_o == $past(byte_wdata_i[CARRY_POS]))
    else $error("status write missed carry");

  done_pulse_a: assert property (
    !op_valid_i |=> !op_done_o && !branch_taken_o)
    else $error("done outside an operation");

endmodule : bad_bit_unit
`default_nettype wire

// [rtl/bad_pkg.sv]
// constants, operation codes and lookups for the bit address decode unit
package bad_pkg;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam int          NUM_RAM_BYTES = 16;
  localparam int          NUM_SFR       = 11;
  localparam int          GROUP_SEL_POS = 7;
  localparam logic [7:0]  RAM_BIT_BASE  = 8'h20;
  localparam logic [7:0]  RAM_BIT_LAST  = 8'h2F;
  localparam logic [2:0]  CARRY_POS     = 3'h7;
  localparam logic [3:0]  SFR_NONE      = 4'hF;

  // special register byte addresses, index order
  localparam logic [7:0] ADDR_PORT0  = 8'h80;
  localparam logic [7:0] ADDR_TIMER  = 8'h88;
  localparam logic [7:0] ADDR_PORT1  = 8'h90;
  localparam logic [7:0] ADDR_SERIAL = 8'h98;
  localparam logic [7:0] ADDR_PORT2  = 8'hA0;
  localparam logic [7:0] ADDR_IEN    = 8'hA8;
  localparam logic [7:0] ADDR_PORT3  = 8'hB0;
  localparam logic [7:0] ADDR_IPRI   = 8'hB8;
  localparam logic [7:0] ADDR_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_ARITH  = 8'hE0;
  localparam logic [7:0] ADDR_SECOND = 8'hF0;

  localparam logic [3:0] IDX_IEN    = 4'h5;
  localparam logic [3:0] IDX_IPRI   = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'h8;

  // implemented bits; missing ones read zero
  localparam logic [7:0] IEN_IMPL_MASK  = 8'h9F;
  localparam logic [7:0] IPRI_IMPL_MASK = 8'h1F;
  localparam logic [7:0] FULL_MASK      = 8'hFF;
  localparam logic [7:0] SFR_RESET      = 8'h00;
  localparam logic [7:0] RAM_RESET      = 8'h00;

  // instruction lengths in bytes
  localparam logic [1:0] LEN_CARRY  = 2'h1;
  localparam logic [1:0] LEN_BIT    = 2'h2;
  localparam logic [1:0] LEN_BRANCH = 2'h3;

  // ---------------------------------------------------------------
  // operations presented by the core sequencer
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE               = 4'h0,
    OP_SET_CARRY          = 4'h1,
    OP_CLEAR_CARRY        = 4'h2,
    OP_INVERT_CARRY       = 4'h3,
    OP_SET_BIT_OP         = 4'h4,
    OP_CLEAR_BIT_OP       = 4'h5,
    OP_INVERT_BIT_OP      = 4'h6,
    OP_AND_INTO_CARRY     = 4'h7,
    OP_AND_NOT_INTO_CARRY = 4'h8,
    OP_OR_INTO_CARRY      = 4'h9,
    OP_OR_NOT_INTO_CARRY  = 4'hA,
    OP_TRANSFER_TO_CARRY  = 4'hB,
    OP_TRANSFER_TO_BIT    = 4'hC,
    OP_BRANCH_IF_SET      = 4'hD,
    OP_BRANCH_IF_CLEAR    = 4'hE,
    OP_BRANCH_SET_CLEAR   = 4'hF
  } bad_op_t;

  // ---------------------------------------------------------------
  // lookups
  // ---------------------------------------------------------------
  // byte address to special register index, SFR_NONE if absent
  function automatic logic [3:0] sfr_index(input logic [7:0] addr);
    case (addr)
      ADDR_PORT0:  sfr_index = 4'h0;
      ADDR_TIMER:  sfr_index = 4'h1;
      ADDR_PORT1:  sfr_index = 4'h2;
      ADDR_SERIAL: sfr_index = 4'h3;
      ADDR_PORT2:  sfr_index = 4'h4;
      ADDR_IEN:    sfr_index = IDX_IEN;
      ADDR_PORT3:  sfr_index = 4'h6;
      ADDR_IPRI:   sfr_index = IDX_IPRI;
      ADDR_STATUS: sfr_index = IDX_STATUS;
      ADDR_ARITH:  sfr_index = 4'h9;
      ADDR_SECOND: sfr_index = 4'hA;
      default:     sfr_index = SFR_NONE;
    endcase
  endfunction : sfr_index

  // mask of bits that hold storage in a special register
  function automatic logic [7:0] sfr_mask(input logic [3:0] idx);
    case (idx)
      IDX_IEN:  sfr_mask = IEN_IMPL_MASK;
      IDX_IPRI: sfr_mask = IPRI_IMPL_MASK;
      default:  sfr_mask = FULL_MASK;
    endcase
  endfunction : sfr_mask

  // encoded length of each operation
  function automatic logic [1:0] op_length(input bad_op_t op);
    case (op)
      OP_SET_CARRY, OP_CLEAR_CARRY, OP_INVERT_CARRY: op_length = LEN_CARRY;
      OP_BRANCH_IF_SET, OP_BRANCH_IF_CLEAR, OP_BRANCH_SET_CLEAR:
        op_length = LEN_BRANCH;
      default: op_length = LEN_BIT;
    endcase
  endfunction : op_length

endpackage : bad_pkg

// [rtl/bad_addr_decode.sv]
// direct bit address to byte address and bit position
`timescale 1ns/1ns
`default_nettype none
module bad_addr_decode
  import bad_pkg::*;
(
  input  wire logic [7:0] bit_addr_i,
  output logic      [7:0] byte_addr_o,
  output logic      [2:0] bit_pos_o,
  output logic            is_ram_o,
  output logic            implemented_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [3:0] idx;
  logic [7:0] impl_mask;

  // group choice, byte address and position
  always_comb begin
    is_ram_o  = !bit_addr_i[GROUP_SEL_POS];
    bit_pos_o = bit_addr_i[2:0];
    if (is_ram_o) begin
      byte_addr_o = RAM_BIT_BASE + {4'h0, bit_addr_i[6:3]};
    end else begin
      byte_addr_o = {bit_addr_i[7:3], 3'h0};
    end
    idx = sfr_index(byte_addr_o);
    impl_mask = sfr_mask(idx);
    implemented_o = is_ram_o ||
                    ((idx != SFR_NONE) && impl_mask[bit_pos_o]);
  end

endmodule : bad_addr_decode
`default_nettype wire

// [test/bad_bit_unit_tb.sv]
// self-checking bench for the bit processor unit
`timescale 1ns/1ns
`default_nettype none
module bad_bit_unit_tb
  import bad_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clock_i;
  logic        rst_b_i;
  logic        op_valid_i;
  bad_op_t     op_code_i;
  logic [7:0]  bit_addr_i;
  logic [7:0]  disp_i;
  logic [15:0] next_pc_i;
  logic [7:0]  byte_addr_i;
  logic        byte_wr_i;
  logic [7:0]  byte_wdata_i;
  logic [7:0]  byte_rdata_o;
  logic        op_done_o;
  logic [1:0]  instr_len_o;
  logic        branch_taken_o;
  logic [15:0] branch_target_o;
  logic        bit_value_o;
  logic        carry_o;
  int          num_errors;
  int          n_checks;
  logic [7:0]  img [16];
  logic [7:0]  a;
  // bit addressable register addresses and their implemented bits
  logic [7:0]  sfr [11] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'hA0, 8'hA8,
                            8'hB0, 8'hB8, 8'hD0, 8'hE0, 8'hF0};
  logic [7:0]  imp [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h9F,
                            8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  rb  [6]  = '{8'h00, 8'h07, 8'h08, 8'h3C, 8'h78, 8'h7F};
  // register bit positions, all on implemented bits
  logic [2:0]  rp  [11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h6, 3'h4,
                            3'h5, 3'h7, 3'h3};
  // carry and bit logic sequence with carry after each step
  bad_op_t     cop [11] = '{OP_CLEAR_CARRY, OP_SET_CARRY, OP_INVERT_CARRY,
    OP_SET_BIT_OP, OP_AND_NOT_INTO_CARRY, OP_OR_NOT_INTO_CARRY,
    OP_AND_INTO_CARRY, OP_OR_INTO_CARRY, OP_TRANSFER_TO_CARRY,
    OP_INVERT_BIT_OP, OP_TRANSFER_TO_BIT};
  logic [7:0]  cad [11] = '{8'h00, 8'h00, 8'h00, 8'hD7, 8'hE0, 8'hE3,
                            8'hE3, 8'hE0, 8'hE3, 8'hD7, 8'hE3};
  logic        cex [11] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
                            1'b0, 1'b1, 1'b1};
  // branch cases: op, bit, displacement, next address, taken, target
  bad_op_t     bop [5]  = '{OP_BRANCH_SET_CLEAR, OP_BRANCH_IF_SET,
    OP_BRANCH_IF_CLEAR, OP_BRANCH_IF_SET, OP_BRANCH_SET_CLEAR};
  logic [7:0]  bad [5]  = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h01};
  logic [7:0]  bdp [5]  = '{8'hFE, 8'h10, 8'h7F, 8'h80, 8'h05};
  logic [15:0] bpc [5]  = '{16'h0100, 16'h0200, 16'hFFF0, 16'h0100,
                            16'h0300};
  logic        btk [5]  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [15:0] btg [5]  = '{16'h00FE, 16'h0210, 16'h006F, 16'h0080,
                            16'h0305};

  bad_bit_unit dut (
    .clock_i         (clock_i),
    .rst_b_i         (rst_b_i),
    .op_valid_i      (op_valid_i),
    .op_code_i       (op_code_i),
    .bit_addr_i      (bit_addr_i),
    .disp_i          (disp_i),
    .next_pc_i       (next_pc_i),
    .byte_addr_i     (byte_addr_i),
    .byte_wr_i       (byte_wr_i),
    .byte_wdata_i    (byte_wdata_i),
    .byte_rdata_o    (byte_rdata_o),
    .op_done_o       (op_done_o),
    .instr_len_o     (instr_len_o),
    .branch_taken_o  (branch_taken_o),
    .branch_target_o (branch_target_o),
    .bit_value_o     (bit_value_o),
    .carry_o         (carry_o)
  );

  // core clock, 4 ns period
  initial clock_i = 1'b0;
  always #2 clock_i = ~clock_i;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one operation, taken at the next edge, outputs looked at after it
  task automatic do_op(input bad_op_t c, input logic [7:0] b,
                       input logic [7:0] d = 8'h00,
                       input logic [15:0] pc = 16'h0000);
    logic [1:0] len;
    len = (c <= OP_INVERT_CARRY) ? 2'h1 :
          (c >= OP_BRANCH_IF_SET) ? 2'h3 : 2'h2;
    @(posedge clock_i);
    op_code_i  <= c;
    bit_addr_i <= b;
    disp_i     <= d;
    next_pc_i  <= pc;
    op_valid_i <= 1'b1;
    @(posedge clock_i);
    op_valid_i <= 1'b0;
    #1;
    check("op_done", op_done_o, 16'h1);
    check("instr_len", instr_len_o, len);
  endtask : do_op

  task automatic wr(input logic [7:0] b, input logic [7:0] d);
    @(posedge clock_i);
    byte_addr_i  <= b;
    byte_wdata_i <= d;
    byte_wr_i    <= 1'b1;
    @(posedge clock_i);
    byte_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input string what, input logic [7:0] b,
                    input logic [7:0] exp);
    @(posedge clock_i);
    byte_addr_i <= b;
    @(posedge clock_i);
    #1;
    check(what, byte_rdata_o, exp);
  endtask : rd

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // hang guard
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    $display("Error watchdog expected end seen hang");
    wrap_up();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    num_errors = 0;
    n_checks = 0;
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    op_code_i = OP_NONE;
    bit_addr_i = 8'h00;
    disp_i = 8'h00;
    next_pc_i = 16'h0000;
    byte_addr_i = 8'h00;
    byte_wr_i = 1'b0;
    byte_wdata_i = 8'h00;
    foreach (img[i]) img[i] = 8'h00;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    check("carry", carry_o, 16'h0);
    foreach (sfr[i]) rd("reset", sfr[i], 8'h00);
    $display("test reset done");

    // ram bits land at byte 20H + a/8, bit a%8
    foreach (rb[i]) begin
      a = rb[i];
      do_op(OP_SET_BIT_OP, a);
      check("old bit", bit_value_o, 16'h0);
      img[a[6:3]][a[2:0]] = 1'b1;
      rd("ram byte", 8'h20 + a[6:3], img[a[6:3]]);
    end
    do_op(OP_INVERT_BIT_OP, 8'h3B);
    check("old bit", bit_value_o, 16'h0);
    rd("ram invert", 8'h27, 8'h18);
    $display("test ram map done");

    // register bits: upper five bits name the register
    foreach (sfr[i]) begin
      a = sfr[i] | {5'h00, rp[i]};
      do_op(OP_SET_BIT_OP, a);
      rd("reg set", sfr[i], (8'h01 << rp[i]) & imp[i]);
      do_op(OP_CLEAR_BIT_OP, a);
      rd("reg clear", sfr[i], 8'h00);
    end
    $display("test register map done");

    // set, clear, invert keep the neighbour bits
    wr(8'hE0, 8'h5A);
    do_op(OP_INVERT_BIT_OP, 8'hE0);
    check("old bit", bit_value_o, 16'h0);
    do_op(OP_CLEAR_BIT_OP, 8'hE3);
    check("old bit", bit_value_o, 16'h1);
    do_op(OP_SET_BIT_OP, 8'hE7);
    rd("arith byte", 8'hE0, 8'hD3);
    $display("test bit state done");

    // carry through the status byte and through bit operations
    wr(8'hD0, 8'h80);
    check("carry", carry_o, 16'h1);
    foreach (cop[i]) begin
      do_op(cop[i], cad[i]);
      check("carry", carry_o, cex[i]);
    end
    rd("status byte", 8'hD0, 8'h80);
    rd("arith byte", 8'hE0, 8'hDB);
    $display("test carry done");

    // bit test branches
    foreach (bop[i]) begin
      do_op(bop[i], bad[i], bdp[i], bpc[i]);
      check("taken", branch_taken_o, btk[i]);
      check("target", branch_target_o, btg[i]);
    end
    rd("ram byte", 8'h20, 8'h80);
    $display("test branch done");

    // absent address and unimplemented bits
    wr(8'h30, 8'hFF);
    rd("absent", 8'h30, 8'h00);
    wr(8'hA8, 8'hFF);
    rd("enable mask", 8'hA8, 8'h9F);
    wr(8'hB8, 8'hFF);
    rd("priority", 8'hB8, 8'h1F);
    $display("test refusal done");
    wrap_up();
  end
endmodule : bad_bit_unit_tb
`default_nettype wire
